/* urs_pkg.sv */
// Package for the serial port status and receive-interrupt block.
// Assumes a single APB clock domain; shared by design and bench.
package urs_pkg;

  // Register byte addresses
  localparam logic [7:0] STA_OFF       = 8'h00; // Status and control
  localparam logic [7:0] RXDATA_OFF    = 8'h04; // Receive data (read pops)
  localparam logic [7:0] TXDATA_OFF    = 8'h08; // Transmit data (write pushes)
  localparam logic [7:0] BAUD_OFF      = 8'h0c; // Bit period in clocks, less one
  localparam logic [7:0] CFG_OFF       = 8'h10; // Frame format
  localparam logic [7:0] IRQ_STAT_OFF  = 8'h14; // Sticky events, write one clears
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h18; // Event mask

  // Status/control field positions
  localparam int TX_PATH_EMPTY_FLAG_BIT   = 8;
  localparam int RXSEL_LSB  = 6;
  localparam int ADDR_CHAR_DETECT_ENABLE_BIT  = 5;
  localparam int RECEIVER_IDLE_FLAG_BIT  = 4;
  localparam int PARITY_FAULT_FLAG_BIT   = 3;
  localparam int FRAMING_FAULT_FLAG_BIT   = 2;
  localparam int RX_OVERRUN_FLAG_BIT   = 1;
  localparam int RX_CHAR_AVAILABLE_BIT  = 0;

  // Config field positions
  localparam int CFG_NINE_BIT = 0;
  localparam int CFG_PEN_BIT  = 1;
  localparam int CFG_PODD_BIT = 2;

  // Interrupt event positions
  localparam int EV_RXLVL = 0;
  localparam int EV_ERR   = 1;
  localparam int EV_OVR   = 2;
  localparam int EV_ADDR  = 3;
  localparam int EV_TXE   = 4;
  localparam int EV_W     = 5;

  // Sizes and reset values
  localparam int RXQ_DEPTH = 8;
  localparam int RXQ_AW    = 3;
  localparam logic [15:0] BAUD_RST = 16'h01b2; // 115200 baud at 50 MHz
  localparam logic [1:0]  RXSEL_RST = 2'h0;

  // Receive interrupt fill thresholds
  localparam logic [3:0] LVL_ANY  = 4'h1;
  localparam logic [3:0] LVL_HALF = 4'h4;
  localparam logic [3:0] LVL_3Q   = 4'h6;

  // Received character with its error marks
  typedef struct packed {
    logic       framing_fault_flag;
    logic       parity_fault_flag;
    logic [8:0] data;
  } urs_rxchar_t;

  // Serial link state
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} urs_state_t;

endpackage

/* urs_top.sv */
// Serial port: transmitter, receiver, status register and receive interrupt.
// Assumes APB3 master on pclk; rxd already synchronous to pclk.
//
// Contract
// - Transmit-empty only when shifter and buffer empty
// - Receive interrupt at selected fill level
// - Ninth bit one marks address in 9-bit
// - Receiver idle flag reads one when idle
// - Parity flag reflects current read character
// - Framing flag reflects current read character
// - Overrun set by hardware, cleared only by software
// - Clearing overrun empties buffer and shifter
// - Data available while buffer not empty
`timescale 1ns/100ps
`default_nettype none
module urs_top
  import urs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Serial pins
  input  wire logic        rxd,
  output logic             txd,
  // Interrupts
  output logic             irq,
  output logic             rx_irq_flag
);
  // Register state
  logic [1:0]   rx_irq_level_select_q;          // Fill level select
  logic         addr_char_detect_enable_q;      // Address detect enable
  logic         rx_overrun_flag_q;              // Sticky overrun
  logic [15:0]  baud_q;                         // Bit period
  logic [2:0]   cfg_q;                          // Nine bit, parity enable, odd
  logic [EV_W-1:0] ev_q;                        // Sticky events
  logic [EV_W-1:0] mask_q;                      // Event mask

  // Receive queue
  urs_rxchar_t  rxq [RXQ_DEPTH];                // Character storage
  logic [RXQ_AW-1:0] rd_ptr_q;                  // Read index
  logic [RXQ_AW-1:0] wr_ptr_q;                  // Write index
  logic [3:0]   cnt_q;                          // Stored characters
  // Transmit path
  logic [8:0]   txbuf_q;                        // Transmit buffer
  logic         txbuf_full_q;                   // Buffer holds a character
  logic [10:0]  tsr_q;                          // Transmit shift register
  logic [3:0]   tx_bits_q;                      // Bits left to shift
  logic [15:0]  tx_tick_q;                      // Bit timer
  // Receive path
  urs_state_t   rx_state_q;                     // Receiver state
  logic [15:0]  rx_tick_q;                      // Bit timer
  logic [3:0]   rx_idx_q;                       // Data bit index
  logic [8:0]   rx_shift_register_q;            // Incoming bits
  logic         rx_parity_fault_flag_q;                      // Parity error of frame
  // Bus decode
  logic         acc;                            // Access phase
  logic         wr;                             // Write takes effect
  logic         rd;                             // Read takes effect
  logic         pop;                            // Receive data read
  logic         rx_overrun_flag_clear;                     // Overrun cleared by write of zero
  logic         push;                           // Receiver delivers character
  logic         push_ok;                        // Delivered character stored
  logic         rx_done;                        // Stop bit sampled
  urs_rxchar_t  rx_new;                         // Character being delivered
  urs_rxchar_t  head;                           // Character at read end
  logic [EV_W-1:0] ev_set;                      // Event pulses
  logic         level_hit;                      // Fill threshold reached
  logic         tx_empty;                       // Both transmit stages empty
  logic         tx_empty_q;                     // Transmit empty one cycle ago
  logic         nine;                           // Nine-bit mode
  // Even parity of a 9-bit word over the active length
  function automatic logic par9(input logic [8:0] d, input logic n9);
    par9 = n9 ? ^d : ^d[7:0];
  endfunction
  assign acc  = psel && penable && clk_en;
  assign wr   = acc && pwrite;
  assign rd   = acc && !pwrite;
  assign pop  = rd && (paddr == RXDATA_OFF) && (cnt_q != 4'h0);
  assign nine = cfg_q[CFG_NINE_BIT];
  assign head = rxq[rd_ptr_q];
  assign tx_empty = !txbuf_full_q && (tx_bits_q == 4'h0);
  // Clearing a set overrun flag by writing zero
  assign rx_overrun_flag_clear = wr && (paddr == STA_OFF) && rx_overrun_flag_q && !pwdata[RX_OVERRUN_FLAG_BIT];
  // Fill level comparison
  always_comb
  begin
    unique case (rx_irq_level_select_q)
      2'h0:    level_hit = cnt_q >= LVL_ANY;
      2'h1:    level_hit = cnt_q >= LVL_HALF;
      2'h2:    level_hit = cnt_q >= LVL_3Q;
      default: level_hit = 1'b0;
    endcase
  end
  // Character leaving the receiver
  assign rx_done = (rx_state_q == S_STOP) && (rx_tick_q == 16'h0000);
  always_comb
  begin
    rx_new.data = rx_shift_register_q;
    rx_new.parity_fault_flag = rx_parity_fault_flag_q;
    rx_new.framing_fault_flag = !rxd;                                          // Stop bit must be high
  end
  // In address mode only address characters are kept
  assign push    = rx_done && !rx_overrun_flag_clear &&
                   (!(addr_char_detect_enable_q && nine) || rx_shift_register_q[8]);
  assign push_ok = push && (cnt_q != 4'(RXQ_DEPTH) || pop);
  // Event pulses; levels fire on their rising edge only, so a clear of the sticky bit holds
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_RXLVL] = level_hit && !rx_irq_flag;                // Flag is the level one cycle ago
    ev_set[EV_ERR]   = push_ok && (rx_new.parity_fault_flag || rx_new.framing_fault_flag);
    ev_set[EV_OVR]   = push && !push_ok;
    ev_set[EV_ADDR]  = push_ok && nine && rx_shift_register_q[8];
    ev_set[EV_TXE]   = tx_empty && !tx_empty_q;
  end
  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_irq_level_select_q     <= RXSEL_RST;
      addr_char_detect_enable_q <= 1'b0;
      baud_q                    <= BAUD_RST;
      cfg_q                     <= 3'h0;
      mask_q                    <= '0;
    end
    else if (wr)
    begin
      // Decode the written register
      if (paddr == STA_OFF)
      begin
        rx_irq_level_select_q     <= pwdata[RXSEL_LSB+1:RXSEL_LSB];
        addr_char_detect_enable_q <= pwdata[ADDR_CHAR_DETECT_ENABLE_BIT];
      end
      if (paddr == BAUD_OFF)
        baud_q <= pwdata[15:0];
      if (paddr == CFG_OFF)
        cfg_q <= pwdata[2:0];
      if (paddr == IRQ_MASK_OFF)
        mask_q <= pwdata[EV_W-1:0];
    end
  end
  // Overrun flag: a clear blocks push in its cycle, so clear wins over set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_overrun_flag_q <= 1'b0;
    else if (clk_en)
    begin
      if (push && !push_ok)
        rx_overrun_flag_q <= 1'b1;
      else if (rx_overrun_flag_clear)
        rx_overrun_flag_q <= 1'b0;
    end
  end
  // Sticky interrupt status, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_q <= '0;
    else if (clk_en)
    begin
      if (wr && paddr == IRQ_STAT_OFF)
        ev_q <= (ev_q & ~pwdata[EV_W-1:0]) | ev_set;
      else
        ev_q <= ev_q | ev_set;
    end
  end
  // Receive queue storage
  always_ff @(posedge pclk)
  begin
    if (clk_en && push_ok)
      rxq[wr_ptr_q] <= rx_new;
  end
  // Receive queue pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      cnt_q    <= 4'h0;
    end
    else if (clk_en)
    begin
      if (rx_overrun_flag_clear)
      begin
        // Empty the buffer
        rd_ptr_q <= '0;
        wr_ptr_q <= '0;
        cnt_q    <= 4'h0;
      end
      else
      begin
        if (pop)
          rd_ptr_q <= rd_ptr_q + 3'h1;
        if (push_ok)
          wr_ptr_q <= wr_ptr_q + 3'h1;
        cnt_q <= cnt_q + {3'h0, push_ok} - {3'h0, pop};
      end
    end
  end
  // Receiver: samples mid-bit, start, data, optional parity, stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_q          <= S_IDLE;
      rx_tick_q           <= 16'h0000;
      rx_idx_q            <= 4'h0;
      rx_shift_register_q <= 9'h000;
      rx_parity_fault_flag_q           <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rx_overrun_flag_clear)
      begin
        // Drop the partial character
        rx_state_q          <= S_IDLE;
        rx_shift_register_q <= 9'h000;
      end
      else if (rx_state_q != S_IDLE && rx_tick_q != 16'h0000)
        rx_tick_q <= rx_tick_q - 16'h0001;
      else
      begin
        unique case (rx_state_q)
          S_IDLE:
            if (!rxd)
            begin
              rx_state_q <= S_START;
              rx_tick_q  <= {1'b0, baud_q[15:1]};
            end
          S_START:
            if (rxd)
              rx_state_q <= S_IDLE;                              // False start
            else
            begin
              rx_state_q          <= S_DATA;
              rx_tick_q           <= baud_q;
              rx_idx_q            <= 4'h0;
              rx_shift_register_q <= 9'h000;
            end
          S_DATA:
          begin
            rx_shift_register_q[rx_idx_q] <= rxd;
            rx_tick_q <= baud_q;
            rx_idx_q  <= rx_idx_q + 4'h1;
            if (rx_idx_q == (nine ? 4'h8 : 4'h7))
              rx_state_q <= cfg_q[CFG_PEN_BIT] && !nine ? S_PAR : S_STOP;
            rx_parity_fault_flag_q <= 1'b0;
          end
          S_PAR:
          begin
            rx_parity_fault_flag_q  <= (par9(rx_shift_register_q, 1'b0) ^ rxd) != cfg_q[CFG_PODD_BIT];
            rx_tick_q  <= baud_q;
            rx_state_q <= S_STOP;
          end
          S_STOP:
            rx_state_q <= S_IDLE;
          default:
            rx_state_q <= S_IDLE;
        endcase
      end
    end
  end
  // Transmitter: buffer feeds shift register, LSB first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txbuf_q      <= 9'h000;
      txbuf_full_q <= 1'b0;
      tsr_q        <= 11'h7ff;
      tx_bits_q    <= 4'h0;
      tx_tick_q    <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (wr && paddr == TXDATA_OFF && !txbuf_full_q)
      begin
        txbuf_q      <= pwdata[8:0];
        txbuf_full_q <= 1'b1;
      end
      if (tx_bits_q == 4'h0)
      begin
        if (txbuf_full_q)
        begin
          // Load start, data, then ninth, parity or stop bit; the top stop goes out only in 11-bit frames
          tsr_q <= {1'b1,
                    nine ? txbuf_q[8] : cfg_q[CFG_PEN_BIT] ? (par9(txbuf_q, 1'b0) ^ cfg_q[CFG_PODD_BIT]) : 1'b1,
                    txbuf_q[7:0], 1'b0};
          tx_bits_q    <= (nine || cfg_q[CFG_PEN_BIT]) ? 4'hb : 4'ha;
          tx_tick_q    <= baud_q;
          txbuf_full_q <= 1'b0;
        end
      end
      else if (tx_tick_q != 16'h0000)
        tx_tick_q <= tx_tick_q - 16'h0001;
      else
      begin
        tsr_q     <= {1'b1, tsr_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        tx_tick_q <= baud_q;
      end
    end
  end
  // Outputs and read data, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      txd         <= 1'b1;
      irq         <= 1'b0;
      rx_irq_flag <= 1'b0;
      tx_empty_q  <= 1'b1;
    end
    else if (clk_en)
    begin
      txd         <= (tx_bits_q == 4'h0) ? 1'b1 : tsr_q[0];
      irq         <= |(ev_q & mask_q);
      rx_irq_flag <= level_hit;
      tx_empty_q  <= tx_empty;
      // No wait state: answer in the cycle after setup
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          STA_OFF:
            prdata <= {23'h0, tx_empty,
                       rx_irq_level_select_q, addr_char_detect_enable_q,
                       rx_state_q == S_IDLE,
                       (cnt_q != 4'h0) && head.parity_fault_flag,
                       (cnt_q != 4'h0) && head.framing_fault_flag,
                       rx_overrun_flag_q,
                       cnt_q != 4'h0};
          RXDATA_OFF:   prdata <= {23'h0, head.data};
          BAUD_OFF:     prdata <= {16'h0, baud_q};
          CFG_OFF:      prdata <= {29'h0, cfg_q};
          IRQ_STAT_OFF: prdata <= {27'h0, ev_q};
          IRQ_MASK_OFF: prdata <= {27'h0, mask_q};
          TXDATA_OFF:   prdata <= 32'h0000_0000;
          default:      pslverr <= 1'b1;
        endcase
      end
      else if (psel && !penable)
        pslverr <= !(paddr inside {STA_OFF, TXDATA_OFF, BAUD_OFF, CFG_OFF,
                                   IRQ_STAT_OFF, IRQ_MASK_OFF, RXDATA_OFF});
    end
  end

endmodule
`default_nettype wire

/* urs_chk.sv */
// Checker for the serial status block: APB timing and status-bit relations.
// Sees only the top module's ports; bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module urs_chk
  import urs_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Serial and interrupt
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq,
  input wire logic        rx_irq_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sta_rd;     // Status read completing
  logic ovr_seen_q; // Overrun seen set by software, not yet written
  assign sta_rd = pready && psel && penable && !pwrite && paddr == STA_OFF;
  // Remember an overrun once a read has shown it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_seen_q <= 1'b0;
    else if (pready && pwrite && paddr == STA_OFF)
      ovr_seen_q <= 1'b0;
    else if (sta_rd && prdata[RX_OVERRUN_FLAG_BIT])
      ovr_seen_q <= 1'b1;
  end
  // Software clearing a set overrun, then the next status read
  sequence clr_s;
    pready && pwrite && paddr == STA_OFF && !pwdata[RX_OVERRUN_FLAG_BIT] && ovr_seen_q;
  endsequence
  sequence sta_rd_s;
    sta_rd;
  endsequence
  ready_zero_a: assert property (psel && !penable && clk_en |=> pready)
    else $error("pready late after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  unmapped_err_a: assert property (pready && paddr > IRQ_MASK_OFF |-> pslverr)
    else $error("no error on unmapped address");
  tx_busy_a: assert property (sta_rd && !txd |-> !prdata[TX_PATH_EMPTY_FLAG_BIT])
    else $error("tx empty while shifting");
  lvl_any_a: assert property (sta_rd && prdata[7:6] == 2'h0 && prdata[RX_CHAR_AVAILABLE_BIT] |-> rx_irq_flag)
    else $error("level flag low with data");
  lvl_rsvd_a: assert property (sta_rd && prdata[7:6] == 2'h3 |-> !rx_irq_flag)
    else $error("level flag with reserved code");
  err_empty_a: assert property (sta_rd && !prdata[RX_CHAR_AVAILABLE_BIT] |-> !prdata[PARITY_FAULT_FLAG_BIT] && !prdata[FRAMING_FAULT_FLAG_BIT])
    else $error("error bit with empty buffer");
  ovr_hold_a: assert property (sta_rd && ovr_seen_q |-> prdata[RX_OVERRUN_FLAG_BIT])
    else $error("overrun cleared by hardware");
  ovr_flush_a: assert property (clr_s ##3 sta_rd_s |-> !prdata[RX_CHAR_AVAILABLE_BIT] && !prdata[RX_OVERRUN_FLAG_BIT])
    else $error("buffer not flushed on overrun clear");
endmodule
`default_nettype wire

/* urs_node.sv */
// Remote serial node: sends frames on rxd and collects frames from txd.
// Assumes the device bit period is BIT_CLKS pclk cycles.
`timescale 1ns/100ps
`default_nettype none
module urs_node
  #(parameter int BIT_CLKS = 4)
(
  // Bit timing clock
  input  wire logic pclk,
  // Serial lines
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] tx_last; // Last character taken from the device
  logic       tx_stop; // Stop bit of the last character
  int         tx_cnt;  // Characters taken so far
  // Send one frame LSB first; bad flips parity, or breaks stop without parity
  task automatic send(input logic [8:0] d, input bit nine, input bit par, input bit bad);
    bit q[$];
    begin
      q.push_back(1'b0);
      for (int i = 0; i < (nine ? 9 : 8); i++)
        q.push_back(d[i]);
      if (par)
        q.push_back(^d[7:0] ^ bad);
      foreach (q[i])
      begin
        rxd <= q[i];
        repeat (BIT_CLKS) @(posedge pclk);
      end
      rxd <= !(bad && !par);
      repeat (BIT_CLKS / 2 + 1) @(posedge pclk);
      rxd <= 1'b1;
      repeat (BIT_CLKS * 2) @(posedge pclk);
    end
  endtask
  // Idle line high; collect 8-bit frames from the device
  initial
  begin
    rxd = 1'b1;
    tx_cnt = 0;
    forever
    begin
      @(negedge txd);
      repeat (BIT_CLKS / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CLKS) @(posedge pclk);
        tx_last[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge pclk);
      tx_stop = txd;
      repeat (BIT_CLKS / 2) @(posedge pclk);
      tx_cnt++;
    end
  end
endmodule
`default_nettype wire

/* test_uart_rx_tx_status_logic.sv */
// Testbench for the serial status block: APB tasks, remote node, checks.
// Assumes a 4-clock bit period after setup; APB tasks wait for pready.
`timescale 1ns/100ps
`default_nettype none
module test_uart_rx_tx_status_logic;
  import urs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, rx_irq_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e;
  int          err_count, checks, s, k, n;
  int          thr[4] = '{1, 4, 6, 9}; // Fill needed per level code
  urs_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq), .rx_irq_flag(rx_irq_flag));
  urs_node #(.BIT_CLKS(4)) node (.pclk(pclk), .txd(txd), .rxd(rxd));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Compare one word
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold the request until pready; only the watchdog ends a hang
      do
        @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Read and compare the masked bits
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, x & m, r & m);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(STA_OFF, 32'h110, '1, "sta_reset");
    rd(BAUD_OFF, {16'h0, BAUD_RST}, '1, "baud_reset");
    rd(8'h1c, 32'h0, '1, "unmapped_data");
    chk("unmapped_err", 32'h1, {31'h0, e});
    wr(BAUD_OFF, 32'h3);
    wr(TXDATA_OFF, 32'ha5);
    rd(STA_OFF, 32'h0, 32'h100, "tx_path_empty_flag_busy");
    n = 0;
    while (node.tx_cnt == 0 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("tx_char", 32'ha5, {24'h0, node.tx_last});
    chk("tx_stop", 32'h1, {31'h0, node.tx_stop});
    rd(STA_OFF, 32'h110, 32'h111, "tx_path_empty_flag_done");
    rd(IRQ_STAT_OFF, 32'h10, 32'h10, "txe_event");
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFF, 32'h10);
    rd(IRQ_MASK_OFF, 32'h10, 32'h1f, "mask_rw");
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(IRQ_STAT_OFF, 32'h10);
    rd(IRQ_STAT_OFF, 32'h0, 32'h10, "txe_clear");
    chk("irq_clear", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFF, 32'h0);
    // Fill levels for every select code, then drain in order
    for (s = 0; s < 4; s++)
    begin
      wr(STA_OFF, 32'(s) << 6);
      for (k = 1; k <= 8; k++)
      begin
        node.send(9'(k * 16 + s), 1'b0, 1'b0, 1'b0);
        chk("rx_level", 32'(k >= thr[s]), {31'h0, rx_irq_flag});
      end
      rd(STA_OFF, 32'h1, 32'h3, "rx_full");
      for (k = 1; k <= 8; k++)
        rd(RXDATA_OFF, 32'(k * 16 + s), 32'h1ff, "rx_data");
      rd(STA_OFF, 32'h0, 32'h1, "rx_empty");
    end
    fork
      node.send(9'h3c, 1'b0, 1'b0, 1'b0);
      begin
        repeat (12) @(posedge pclk);
        rd(STA_OFF, 32'h0, 32'h10, "receiver_idle_flag_busy");
      end
    join
    rd(RXDATA_OFF, 32'h3c, 32'h1ff, "receiver_idle_flag_char");
    wr(CFG_OFF, 32'h2);
    node.send(9'h07, 1'b0, 1'b1, 1'b1);
    node.send(9'h03, 1'b0, 1'b1, 1'b0);
    rd(STA_OFF, 32'h9, 32'hd, "parity_fault_flag_head");
    rd(RXDATA_OFF, 32'h07, 32'hff, "parity_fault_flag_char");
    rd(STA_OFF, 32'h1, 32'hd, "parity_fault_flag_next");
    rd(RXDATA_OFF, 32'h03, 32'hff, "good_char");
    wr(CFG_OFF, 32'h0);
    node.send(9'h5a, 1'b0, 1'b0, 1'b1);
    rd(STA_OFF, 32'h5, 32'hd, "framing_fault_flag_head");
    rd(RXDATA_OFF, 32'h5a, 32'hff, "framing_fault_flag_char");
    rd(STA_OFF, 32'h0, 32'hd, "framing_fault_flag_gone");
    wr(STA_OFF, 32'h0);
    for (k = 0; k < 9; k++)
      node.send(9'(k), 1'b0, 1'b0, 1'b0);
    rd(STA_OFF, 32'h3, 32'h3, "ovr_set");
    rd(IRQ_STAT_OFF, 32'h4, 32'h4, "ovr_event");
    wr(STA_OFF, 32'h2);
    rd(STA_OFF, 32'h2, 32'h2, "ovr_keep");
    wr(STA_OFF, 32'h0);
    rd(STA_OFF, 32'h0, 32'h3, "ovr_flush");
    wr(CFG_OFF, 32'h1);
    wr(STA_OFF, 32'h20);
    node.send(9'h055, 1'b1, 1'b0, 1'b0);
    rd(STA_OFF, 32'h0, 32'h1, "addr_skip");
    node.send(9'h1aa, 1'b1, 1'b0, 1'b0);
    rd(RXDATA_OFF, 32'h1aa, 32'h1ff, "addr_keep");
    wr(CFG_OFF, 32'h0);
    node.send(9'h55, 1'b0, 1'b0, 1'b0);
    rd(RXDATA_OFF, 32'h55, 32'h1ff, "addr_8bit");
    summarize();
  end
endmodule
bind urs_top urs_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq), .rx_irq_flag(rx_irq_flag));
`default_nettype wire
